// ==== hdl/ac_line_detect_softstart_regs.sv ====
/*
  configuration bank for ac line detection, line period limits, current
  loop coefficients and soft start, with the logic those settings steer.
  assumes the management bus front end delivers one-cycle read and write
  strobes with a 16-bit command address, synchronous to mclk.
*/
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module ac_line_detect_softstart_regs
  import line_cfg_pkg::*;
#(
  parameter int LINE_TICK_CYCLES = LINE_TICK_CYC,
  parameter int MS_TICK_CYCLES   = MS_TICK_CYC
) (
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  output logic [DATA_W-1:0]       reg_rdata,
  output logic                    reg_rvalid,
  output logic                    reg_hit,
  input  wire logic               sample_valid,
  input  wire logic [THR_W-1:0]   vac_level,
  input  wire logic               high_line,
  input  wire logic               inrush_done,
  output logic [7:0]              loop_gain,
  output logic [7:0]              loop_zero,
  output logic                    line_above_thr,
  output logic                    zero_cross,
  output logic [7:0]              line_period,
  output logic                    period_too_short,
  output logic                    period_too_long,
  output logic                    soft_ramp_active,
  output logic                    soft_ramp_done,
  output logic [RAMP_MS_W-1:0]    soft_ramp_elapsed
);
  reg_req_s   req;
  line_stat_s stat;

  logic [7:0] thr_cfg_ff,   nxt_thr_cfg;
  logic [7:0] per_min_ff,   nxt_per_min;
  logic [7:0] per_max_ff,   nxt_per_max;
  logic [7:0] low_gain_ff,  nxt_low_gain;
  logic [7:0] low_zero_ff,  nxt_low_zero;
  logic [7:0] high_gain_ff, nxt_high_gain;
  logic [7:0] high_zero_ff, nxt_high_zero;
  logic [7:0] ramp_cfg_ff,  nxt_ramp_cfg;
  logic [7:0] rdata_ff,     nxt_rdata;
  logic       rvalid_ff,    nxt_rvalid;
  logic [7:0] gain_ff,      nxt_gain;
  logic [7:0] zero_ff,      nxt_zero;

  localparam int LT_W = $clog2(LINE_TICK_CYCLES);
  localparam int MS_W = $clog2(MS_TICK_CYCLES);
  logic [LT_W-1:0] lt_cnt_ff, nxt_lt_cnt;
  logic [MS_W-1:0] ms_cnt_ff, nxt_ms_cnt;
  logic            lt_tick_ff, nxt_lt_tick;
  logic            ms_tick_ff, nxt_ms_tick;

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return (a >= LINE_THR_CFG_A) && (a <= SOFT_RAMP_A);
  endfunction

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  //////////////////////////////////////////////////////////////////////////////
  // register writes

  always_comb begin
    nxt_thr_cfg = thr_cfg_ff;
    nxt_per_min = per_min_ff;
    nxt_per_max = per_max_ff;
    nxt_low_gain = low_gain_ff;
    nxt_low_zero = low_zero_ff;
    nxt_high_gain = high_gain_ff;
    nxt_high_zero = high_zero_ff;
    nxt_ramp_cfg = ramp_cfg_ff;
    if (req.wr) begin
      unique case (req.addr)
        LINE_THR_CFG_A: nxt_thr_cfg = req.wdata;
        PERIOD_MIN_A:   nxt_per_min = req.wdata;
        PERIOD_MAX_A:   nxt_per_max = req.wdata;
        LOW_GAIN_A:     nxt_low_gain = req.wdata;
        LOW_ZERO_A:     nxt_low_zero = req.wdata;
        HIGH_GAIN_A:    nxt_high_gain = req.wdata;
        HIGH_ZERO_A:    nxt_high_zero = req.wdata;
        SOFT_RAMP_A:    nxt_ramp_cfg = req.wdata & SOFT_RAMP_MASK;
        default: begin
          // readback and unmapped addresses drop the write
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      thr_cfg_ff <= THR_CFG_RST;
      per_min_ff <= PERIOD_MIN_RST;
      per_max_ff <= PERIOD_MAX_RST;
      low_gain_ff <= COEF_RST;
      low_zero_ff <= COEF_RST;
      high_gain_ff <= COEF_RST;
      high_zero_ff <= COEF_RST;
      ramp_cfg_ff <= SOFT_RAMP_RST;
    end else begin
      thr_cfg_ff <= nxt_thr_cfg;
      per_min_ff <= nxt_per_min;
      per_max_ff <= nxt_per_max;
      low_gain_ff <= nxt_low_gain;
      low_zero_ff <= nxt_low_zero;
      high_gain_ff <= nxt_high_gain;
      high_zero_ff <= nxt_high_zero;
      ramp_cfg_ff <= nxt_ramp_cfg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register reads, answered one cycle after the strobe

  always_comb begin
    nxt_rvalid = req.rd;
    nxt_rdata = rdata_ff;
    if (req.rd) begin
      unique case (req.addr)
        LINE_THR_CFG_A: nxt_rdata = thr_cfg_ff;
        LINE_THR_RB_A: begin
          // manual mode has no derived value to report
          nxt_rdata = thr_cfg_ff[AUTO_EN_BIT] ? {1'b0, stat.auto_thr} : 8'h00;
        end
        PERIOD_MIN_A:   nxt_rdata = per_min_ff;
        PERIOD_MAX_A:   nxt_rdata = per_max_ff;
        LOW_GAIN_A:     nxt_rdata = low_gain_ff;
        LOW_ZERO_A:     nxt_rdata = low_zero_ff;
        HIGH_GAIN_A:    nxt_rdata = high_gain_ff;
        HIGH_ZERO_A:    nxt_rdata = high_zero_ff;
        SOFT_RAMP_A:    nxt_rdata = ramp_cfg_ff & SOFT_RAMP_MASK;
        default:        nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign reg_hit = addr_known(req.addr);

  //////////////////////////////////////////////////////////////////////////////
  // coefficient pair selection

  always_comb begin
    nxt_gain = high_line ? high_gain_ff : low_gain_ff;
    nxt_zero = high_line ? high_zero_ff : low_zero_ff;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gain_ff <= COEF_RST;
      zero_ff <= COEF_RST;
    end else begin
      gain_ff <= nxt_gain;
      zero_ff <= nxt_zero;
    end
  end

  assign loop_gain = gain_ff;
  assign loop_zero = zero_ff;

  //////////////////////////////////////////////////////////////////////////////
  // period tick and millisecond tick dividers

  always_comb begin
    nxt_lt_tick = (lt_cnt_ff == LT_W'(LINE_TICK_CYCLES - 1));
    nxt_lt_cnt = nxt_lt_tick ? '0 : lt_cnt_ff + 1'b1;
    nxt_ms_tick = (ms_cnt_ff == MS_W'(MS_TICK_CYCLES - 1));
    nxt_ms_cnt = nxt_ms_tick ? '0 : ms_cnt_ff + 1'b1;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lt_cnt_ff <= '0;
      ms_cnt_ff <= '0;
      lt_tick_ff <= 1'b0;
      ms_tick_ff <= 1'b0;
    end else begin
      lt_cnt_ff <= nxt_lt_cnt;
      ms_cnt_ff <= nxt_ms_cnt;
      lt_tick_ff <= nxt_lt_tick;
      ms_tick_ff <= nxt_ms_tick;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // line detection and soft start

  line_crossing_monitor line_crossing_monitor_inst (
    .mclk         (mclk),
    .resetn       (resetn),
    .sample_valid (sample_valid),
    .vac_level    (vac_level),
    .auto_en      (thr_cfg_ff[AUTO_EN_BIT]),
    .manual_thr   (thr_cfg_ff[THR_W-1:0]),
    .period_tick  (lt_tick_ff),
    .period_min   (per_min_ff),
    .period_max   (per_max_ff),
    .above_thr    (line_above_thr),
    .stat         (stat)
  );

  assign zero_cross = stat.line_cycle;
  assign line_period = stat.period;
  assign period_too_short = stat.too_short;
  assign period_too_long = stat.too_long;

  soft_ramp_sequencer soft_ramp_sequencer_inst (
    .mclk         (mclk),
    .resetn       (resetn),
    .inrush_done  (inrush_done),
    .line_cycle   (stat.line_cycle),
    .ms_tick      (ms_tick_ff),
    .delay_code   (ramp_cfg_ff[SS_DELAY_LSB +: SS_CODE_W]),
    .time_code    (ramp_cfg_ff[SS_CODE_W-1:0]),
    .ramp_active  (soft_ramp_active),
    .ramp_done    (soft_ramp_done),
    .ramp_elapsed (soft_ramp_elapsed)
  );
endmodule
`default_nettype wire

// ==== hdl/line_cfg_pkg.sv ====
/*
  shared constants and carriers of the ac line detection and soft start
  configuration bank. assumes one 125 MHz core clock.
*/
`default_nettype none
package line_cfg_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 8;
  localparam logic [15:0] LINE_THR_CFG_A  = 16'hfe25;
  localparam logic [15:0] LINE_THR_RB_A   = 16'hfe26;
  localparam logic [15:0] PERIOD_MIN_A    = 16'hfe27;
  localparam logic [15:0] PERIOD_MAX_A    = 16'hfe28;
  localparam logic [15:0] LOW_GAIN_A      = 16'hfe29;
  localparam logic [15:0] LOW_ZERO_A      = 16'hfe2a;
  localparam logic [15:0] HIGH_GAIN_A     = 16'hfe2b;
  localparam logic [15:0] HIGH_ZERO_A     = 16'hfe2c;
  localparam logic [15:0] SOFT_RAMP_A     = 16'hfe2d;
  // field layout
  localparam int          AUTO_EN_BIT     = 7;
  localparam int          THR_W           = 7;
  localparam int          SS_DELAY_LSB    = 3;
  localparam int          SS_CODE_W       = 3;
  localparam logic [7:0]  SOFT_RAMP_MASK  = 8'h3f;
  localparam logic [7:0]  THR_MASK        = 8'h7f;
  // reset values
  localparam logic [7:0]  THR_CFG_RST     = 8'h00;
  localparam logic [7:0]  PERIOD_MIN_RST  = 8'h00;
  localparam logic [7:0]  PERIOD_MAX_RST  = 8'hff;
  localparam logic [7:0]  COEF_RST        = 8'h00;
  localparam logic [7:0]  SOFT_RAMP_RST   = 8'h00;
  // timing
  localparam real         CLK_PERIOD_NS   = 8.0;
  localparam real         LINE_TICK_US    = 163.84;
  localparam real         MS_TICK_MS      = 1.0;
  localparam int          LINE_TICK_CYC   = int'(LINE_TICK_US * 1000.0 / CLK_PERIOD_NS);
  localparam int          MS_TICK_CYC     = int'(MS_TICK_MS * 1000000.0 / CLK_PERIOD_NS);
  localparam int          RAMP_MS_W       = 10;
  localparam int          AVG_SHIFT       = 4;
  typedef logic [RAMP_MS_W-1:0] ramp_ms_t;
  localparam ramp_ms_t    RAMP_MS_TABLE [8] = '{
    10'h070, 10'h0a8, 10'h0e0, 10'h118, 10'h188, 10'h1f8, 10'h268, 10'h2d8};

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [15:0]       addr;
    logic [7:0]        wdata;
  } reg_req_s;

  typedef struct packed {
    logic              line_cycle;
    logic              too_short;
    logic              too_long;
    logic [7:0]        period;
    logic [THR_W-1:0]  auto_thr;
  } line_stat_s;

  typedef enum logic [1:0] {SS_IDLE, SS_DELAY, SS_RAMP, SS_DONE} ss_state_e;
endpackage
`default_nettype wire

// ==== hdl/line_crossing_monitor.sv ====
/*
  threshold compare, zero crossing and line period measurement.
  assumes samples and period ticks are single-cycle strobes of mclk.
*/
`default_nettype none
module line_crossing_monitor
  import line_cfg_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             sample_valid,
  input  wire logic [THR_W-1:0] vac_level,
  input  wire logic             auto_en,
  input  wire logic [THR_W-1:0] manual_thr,
  input  wire logic             period_tick,
  input  wire logic [7:0]       period_min,
  input  wire logic [7:0]       period_max,
  output logic                  above_thr,
  output line_stat_s            stat
);
  logic [THR_W+AVG_SHIFT-1:0] avg_ff, nxt_avg;
  logic                       above_ff, nxt_above;
  logic [7:0]                 cnt_ff, nxt_cnt;
  line_stat_s                 stat_ff, nxt_stat;
  logic [THR_W-1:0]           thr;
  logic                       rise;

  always_comb begin
    nxt_avg = avg_ff;
    if (sample_valid) begin
      // slow average of the line level keeps the auto threshold near mid-swing
      nxt_avg = avg_ff - (avg_ff >> AVG_SHIFT) + {{AVG_SHIFT{1'b0}}, vac_level};
    end
    thr = auto_en ? avg_ff[THR_W+AVG_SHIFT-1:AVG_SHIFT] : manual_thr;
    nxt_above = above_ff;
    if (sample_valid) begin
      nxt_above = (vac_level >= thr);
    end
    rise = nxt_above && !above_ff;
    nxt_cnt = cnt_ff;
    if (rise) begin
      nxt_cnt = 8'h00;
    end else if (period_tick && cnt_ff != 8'hff) begin
      nxt_cnt = cnt_ff + 8'h01;
    end
    nxt_stat = stat_ff;
    nxt_stat.line_cycle = rise;
    nxt_stat.auto_thr = avg_ff[THR_W+AVG_SHIFT-1:AVG_SHIFT];
    if (rise) begin
      nxt_stat.period = cnt_ff;
      nxt_stat.too_short = cnt_ff < period_min;
      nxt_stat.too_long = cnt_ff > period_max;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      avg_ff <= '0;
      above_ff <= 1'b0;
      cnt_ff <= 8'h00;
      stat_ff <= '0;
    end else begin
      avg_ff <= nxt_avg;
      above_ff <= nxt_above;
      cnt_ff <= nxt_cnt;
      stat_ff <= nxt_stat;
    end
  end

  assign above_thr = above_ff;
  assign stat = stat_ff;
endmodule
`default_nettype wire

// ==== hdl/soft_ramp_sequencer.sv ====
/*
  soft start sequencing: line cycle delay after inrush, then timed ramp.
  assumes line_cycle and ms_tick are one-cycle strobes of mclk.
*/
`default_nettype none
module soft_ramp_sequencer
  import line_cfg_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 inrush_done,
  input  wire logic                 line_cycle,
  input  wire logic                 ms_tick,
  input  wire logic [SS_CODE_W-1:0] delay_code,
  input  wire logic [SS_CODE_W-1:0] time_code,
  output logic                      ramp_active,
  output logic                      ramp_done,
  output logic [RAMP_MS_W-1:0]      ramp_elapsed
);
  ss_state_e              st_ff, nxt_st;
  logic                   inrush_q_ff, nxt_inrush_q;
  logic [SS_CODE_W-1:0]   cyc_ff, nxt_cyc;
  logic [SS_CODE_W-1:0]   dly_ff, nxt_dly;
  ramp_ms_t               len_ff, nxt_len;
  ramp_ms_t               ms_ff, nxt_ms;

  always_comb begin
    nxt_st = st_ff;
    nxt_inrush_q = inrush_done;
    nxt_cyc = cyc_ff;
    nxt_dly = dly_ff;
    nxt_len = len_ff;
    nxt_ms = ms_ff;
    unique case (st_ff)
      SS_IDLE: begin
        if (inrush_done && !inrush_q_ff) begin
          // settings are frozen at start so a mid-ramp write cannot glitch it
          nxt_dly = delay_code;
          nxt_len = RAMP_MS_TABLE[time_code];
          nxt_cyc = '0;
          nxt_ms = '0;
          nxt_st = (delay_code == '0) ? SS_RAMP : SS_DELAY;
        end
      end
      SS_DELAY: begin
        if (line_cycle) begin
          nxt_cyc = cyc_ff + 1'b1;
          if (cyc_ff + 1'b1 == dly_ff) begin
            nxt_st = SS_RAMP;
          end
        end
      end
      SS_RAMP: begin
        if (ms_tick) begin
          nxt_ms = ms_ff + 1'b1;
          if (ms_ff + 1'b1 == len_ff) begin
            nxt_st = SS_DONE;
          end
        end
      end
      SS_DONE: begin
      end
    endcase
    // losing the inrush release aborts and rearms the sequence
    if (!inrush_done) begin
      nxt_st = SS_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= SS_IDLE;
      inrush_q_ff <= 1'b0;
      cyc_ff <= '0;
      dly_ff <= '0;
      len_ff <= '0;
      ms_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      inrush_q_ff <= nxt_inrush_q;
      cyc_ff <= nxt_cyc;
      dly_ff <= nxt_dly;
      len_ff <= nxt_len;
      ms_ff <= nxt_ms;
    end
  end

  assign ramp_active = (st_ff == SS_RAMP);
  assign ramp_done = (st_ff == SS_DONE);
  assign ramp_elapsed = ms_ff;
endmodule
`default_nettype wire

// ==== dv/line_cfg_asserts.sv ====
/*
  port-level checker of the line detect and soft start bank.
  assumes it is bound to the top module and sees its ports only.
*/
`default_nettype none
module line_cfg_asserts
  import line_cfg_pkg::*;
#(
  parameter int LINE_TICK_CYCLES = 8,
  parameter int MS_TICK_CYCLES   = 16
) (
  input wire logic                 mclk,
  input wire logic                 resetn,
  input wire logic                 reg_rd,
  input wire logic [ADDR_W-1:0]    reg_addr,
  input wire logic [DATA_W-1:0]    reg_rdata,
  input wire logic                 reg_rvalid,
  input wire logic                 reg_hit,
  input wire logic                 inrush_done,
  input wire logic                 line_above_thr,
  input wire logic                 zero_cross,
  input wire logic                 soft_ramp_active,
  input wire logic                 soft_ramp_done,
  input wire logic [RAMP_MS_W-1:0] soft_ramp_elapsed
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe without answer");
  a_stray_valid: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without read strobe");
  a_hit_decode: assert property (reg_hit == (reg_addr >= LINE_THR_CFG_A
    && reg_addr <= SOFT_RAMP_A))
    else $error("address decode wrong");
  a_unmapped_zero: assert property (reg_rd && !reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_readback_reserved_bits: assert property (reg_rd && reg_addr == LINE_THR_RB_A |=> !reg_rdata[7])
    else $error("readback top bit set");
  a_ramp_reserved_bits: assert property (reg_rd && reg_addr == SOFT_RAMP_A
    |=> reg_rdata[7:6] == 2'b00)
    else $error("soft ramp top bits set");
  a_cross_pulse: assert property (zero_cross |-> line_above_thr ##1 !zero_cross)
    else $error("crossing pulse malformed");
  a_ramp_states: assert property (!(soft_ramp_active && soft_ramp_done))
    else $error("ramp active and done together");
  a_ramp_abort: assert property ($fell(inrush_done)
    |-> ##[1:3] !(soft_ramp_active || soft_ramp_done))
    else $error("ramp not stopped after inrush low");
  a_elapsed_cap: assert property (soft_ramp_active |-> soft_ramp_elapsed <= 10'h2d8)
    else $error("ramp elapsed beyond longest time");
  a_no_early_ramp: assert property ($rose(soft_ramp_active)
    |-> inrush_done && $past(inrush_done))
    else $error("ramp began without inrush");
  c_ramp_done: cover property ($rose(soft_ramp_done));
  c_cross: cover property (zero_cross);
  c_unmapped: cover property (reg_rd && !reg_hit);
endmodule
bind ac_line_detect_softstart_regs line_cfg_asserts #(
  .LINE_TICK_CYCLES(LINE_TICK_CYCLES),
  .MS_TICK_CYCLES(MS_TICK_CYCLES)
) line_cfg_asserts_inst (.mclk, .resetn, .reg_rd, .reg_addr, .reg_rdata, .reg_rvalid,
  .reg_hit, .inrush_done, .line_above_thr, .zero_cross, .soft_ramp_active,
  .soft_ramp_done, .soft_ramp_elapsed);
`default_nettype wire

// ==== dv/ac_line_detect_softstart_regs_test.sv ====
/*
  self-checking bench of the line detect and soft start bank.
  assumes shortened tick parameters so every ramp ends within thousands of cycles.
*/
`default_nettype none
module ac_line_detect_softstart_regs_test import line_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LT = 8;
  localparam int MT = 16;
  localparam int RAMP_MS [8] = '{112, 168, 224, 280, 392, 504, 616, 728};
  typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic mclk = 1'b0;
  logic resetn, reg_wr, reg_rd, sample_valid, high_line, inrush_done;
  logic reg_rvalid, reg_hit, line_above_thr, zero_cross, period_too_short, period_too_long;
  logic soft_ramp_active, soft_ramp_done;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, loop_gain, loop_zero, line_period, last_rd;
  logic [6:0]  vac_level;
  logic [9:0]  soft_ramp_elapsed;
  int          fail_count, compares, zc_count, zc0;
  // unmapped and read-only rows prove writes there land nowhere
  row_s rows [10] = '{'{16'hfe25, 8'h35, 8'h35}, '{16'hfe27, 8'h12, 8'h12},
    '{16'hfe28, 8'hc8, 8'hc8}, '{16'hfe29, 8'ha1, 8'ha1}, '{16'hfe2a, 8'hb2, 8'hb2},
    '{16'hfe2b, 8'hc3, 8'hc3}, '{16'hfe2c, 8'hd4, 8'hd4}, '{16'hfe2d, 8'hff, 8'h3f},
    '{16'hfe26, 8'h55, 8'h00}, '{16'hfe30, 8'h77, 8'h00}};
  logic [7:0] rst_exp [9] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  ac_line_detect_softstart_regs #(.LINE_TICK_CYCLES(LT), .MS_TICK_CYCLES(MT))
    ac_line_detect_softstart_regs_inst (.mclk, .resetn, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .reg_hit, .sample_valid, .vac_level, .high_line,
    .inrush_done, .loop_gain, .loop_zero, .line_above_thr, .zero_cross, .line_period,
    .period_too_short, .period_too_long, .soft_ramp_active, .soft_ramp_done,
    .soft_ramp_elapsed);

  always #4 mclk = ~mclk;
  always @(posedge mclk) if (zero_cross === 1'b1) zc_count++;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    last_rd = reg_rdata;
    chk(16'(reg_rvalid), 16'h0001);
  endtask
  task automatic samp(input logic [6:0] v);
    @(posedge mclk);
    sample_valid <= 1'b1;
    vac_level <= v;
    @(posedge mclk);
    sample_valid <= 1'b0;
  endtask
  // one line cycle is 4*n clocks, so n/2 period ticks at LT=8
  task automatic line_cyc(input int n);
    repeat (n) samp(7'h00);
    repeat (n) samp(7'h7f);
  endtask
  task automatic ramp(input logic [2:0] code);
    int n;
    wr(SOFT_RAMP_A, {5'h00, code});
    inrush_done <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(16'(soft_ramp_active), 16'h0001);
    n = 0;
    while (soft_ramp_done !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      if (soft_ramp_active === 1'b1) n++;
    end
    #1;
    chk(16'(soft_ramp_elapsed), 16'(RAMP_MS[code]));
    chk(16'(n >= RAMP_MS[code] * MT - MT - 4 && n <= RAMP_MS[code] * MT + 4), 16'h1);
    @(posedge mclk);
    inrush_done <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic stop_test;
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    // all scenarios need about 51k cycles, ramps being the bulk
    repeat (80000) @(posedge mclk);
    fail_count++;
    stop_test();
  end
  initial begin
    {resetn, reg_wr, reg_rd, sample_valid, high_line, inrush_done} = 6'h00;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    vac_level = 7'h00;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(16'(last_rd), 16'(rows[i].e));
    end
    repeat (3) @(posedge mclk);
    #1;
    chk({loop_gain, loop_zero}, 16'ha1b2);
    @(posedge mclk);
    high_line <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk({loop_gain, loop_zero}, 16'hc3d4);
    wr(LINE_THR_CFG_A, 8'h40);
    samp(7'h3f);
    repeat (2) @(posedge mclk);
    #1;
    chk(16'(line_above_thr), 16'h0000);
    samp(7'h40);
    repeat (2) @(posedge mclk);
    #1;
    chk(16'(line_above_thr), 16'h0001);
    wr(PERIOD_MIN_A, 8'h08);
    wr(PERIOD_MAX_A, 8'h1e);
    zc0 = zc_count;
    line_cyc(40);
    line_cyc(40);
    #1;
    chk(16'(zc_count - zc0), 16'h0002);
    chk(16'(line_period >= 8'd19 && line_period <= 8'd21), 16'h1);
    chk({period_too_short, period_too_long}, 16'h0000);
    line_cyc(8);
    line_cyc(8);
    #1;
    chk({period_too_short, period_too_long}, 16'h0002);
    line_cyc(200);
    line_cyc(200);
    #1;
    chk({period_too_short, period_too_long}, 16'h0001);
    rd(LINE_THR_RB_A);
    chk(16'(last_rd), 16'h0000);
    wr(LINE_THR_CFG_A, 8'hc0);
    repeat (300) samp(7'h40);
    rd(LINE_THR_RB_A);
    chk(16'(last_rd >= 8'h30 && last_rd <= 8'h50), 16'h1);
    // mid-run reset must bring back every start value
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    foreach (rst_exp[i]) begin
      rd(LINE_THR_CFG_A + 16'(i));
      chk(16'(last_rd), 16'(rst_exp[i]));
    end
    for (int c = 0; c < 8; c++) ramp(3'(c));
    wr(LINE_THR_CFG_A, 8'h40);
    wr(SOFT_RAMP_A, 8'h10);
    inrush_done <= 1'b1;
    line_cyc(10);
    #1;
    chk(16'(soft_ramp_active), 16'h0000);
    line_cyc(10);
    #1;
    chk(16'(soft_ramp_active), 16'h0001);
    @(posedge mclk);
    inrush_done <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk({soft_ramp_active, soft_ramp_done}, 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
